//--- hw/rkm_regs.svh
`ifndef RKM_REGS_SVH
`define RKM_REGS_SVH
// How it works
// R1 - top rank boundary is 10-bit sum of rank sizes, 64 MB units, upper bits zero
// R2 - while the stolen-region lock is high, boundary and attribute writes are ignored
// R3 - each attribute register holds two bytes: even rank low, odd rank high
// R4 - attribute byte bits 6:0 give the geometry configuration index
// R5 - attribute byte bit 7 selects four banks (0) or eight banks (1)
// R6 - the selected rank's attribute byte sets page size and bank count
// R7 - software leaves attribute bytes zero for unpopulated ranks
// R8 - configurations 0 to 7 map to fixed row, column and page sizes
// R9 - write to precharge on one bank waits the programmed 5-bit clock count
// R10 - read to precharge on one bank waits the programmed 4-bit clock count
// R11 - precharge to precharge on one rank waits the programmed 2-bit count
// R12 - chip select comes from comparing the address to ascending rank boundaries
// R13 - per-bank read/write counters and per-rank precharge counter gate every precharge

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RKM_ADDR_W 12
`define RKM_TOPB_OFS 12'h206
`define RKM_ATTR01_OFS 12'h208
`define RKM_ATTR23_OFS 12'h20a
`define RKM_PCHG_OFS 12'h250
`define RKM_RST_VAL 16'h0000

// ----------------------------------------
// field positions
// ----------------------------------------
`define RKM_TOPB_MSB 9
`define RKM_WRG_MSB 10
`define RKM_WRG_LSB 6
`define RKM_RDG_MSB 5
`define RKM_RDG_LSB 2
`define RKM_PPG_MSB 1
`define RKM_PPG_LSB 0
`define RKM_BANK8_BIT 7
`define RKM_CFG_MSB 6

// ----------------------------------------
// geometry table, one nibble per configuration, one bit for page size
// ----------------------------------------
`define RKM_CFG_MAX 7'h07
`define RKM_ROW_TBL 32'hdecddedd
`define RKM_COL_TBL 32'haaaaaa9a
`define RKM_PG8K_TBL 8'hfd

`endif

//--- hw/rkm_pkg.sv
package rkm_pkg;

  typedef enum logic [1:0] {
    RKM_NOP = 2'b00,
    RKM_RD = 2'b01,
    RKM_WR = 2'b10,
    RKM_PRE = 2'b11
  } rkm_kind_t;

  typedef struct packed {
    logic valid;
    rkm_kind_t kind;
    logic [1:0] rank;
    logic [2:0] bank;
  } rkm_cmd_t;

  typedef struct packed {
    logic cfg_ok;
    logic banks8;
    logic page_8k;
    logic [3:0] row_bits;
    logic [3:0] col_bits;
  } rkm_geom_t;

endpackage

//--- hw/rkm_pchg_trk.sv
`timescale 1ns/1ns
`default_nettype none
module rkm_pchg_trk #(
  parameter int CW = 5
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire rkm_pkg::rkm_cmd_t cmd_i,
  input wire logic [4:0] wr_gap_i,
  input wire logic [3:0] rd_gap_i,
  input wire logic [1:0] pp_gap_i,
  output logic [31:0] allow_o
);

  if (CW < 5 || CW > 16)
  begin : g_bad_cw
    $error("rkm_pchg_trk: CW must be 5 to 16");
  end

  logic [CW-1:0] wr_cnt_r [32];
  logic [CW-1:0] rd_cnt_r [32];
  logic [CW-1:0] pp_cnt_r [4];
  logic [CW-1:0] wr_cnt_nxt [32];
  logic [CW-1:0] rd_cnt_nxt [32];
  logic [CW-1:0] pp_cnt_nxt [4];
  logic [31:0] allow_nxt;
  logic [4:0] idx;

  function automatic logic [CW-1:0] step(input logic [CW-1:0] c, input logic hit);
    if (hit)
      step = {{(CW-1){1'b0}}, 1'b1};
    else if (&c)
      step = c;
    else
      step = c + {{(CW-1){1'b0}}, 1'b1};
  endfunction

  assign idx = {cmd_i.rank, cmd_i.bank};

  // ----------------------------------------
  // counters since last read, write, precharge
  // ----------------------------------------
  always_comb
  begin
    for (int i = 0; i < 32; i++)
    begin
      wr_cnt_nxt[i] = step(wr_cnt_r[i], cmd_i.valid && cmd_i.kind == rkm_pkg::RKM_WR && idx == i); // R13
      rd_cnt_nxt[i] = step(rd_cnt_r[i], cmd_i.valid && cmd_i.kind == rkm_pkg::RKM_RD && idx == i); // R13
    end
    for (int r = 0; r < 4; r++)
      pp_cnt_nxt[r] = step(pp_cnt_r[r], cmd_i.valid && cmd_i.kind == rkm_pkg::RKM_PRE
                                        && cmd_i.rank == r); // R13
    for (int i = 0; i < 32; i++)
      allow_nxt[i] = wr_cnt_nxt[i] >= CW'(wr_gap_i) // R9
                     && rd_cnt_nxt[i] >= CW'(rd_gap_i) // R10
                     && pp_cnt_nxt[i/4/2] >= CW'(pp_gap_i); // R11
  end

  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < 32; i++)
    begin
      wr_cnt_r[i] <= sys_rst_i ? {CW{1'b1}} : wr_cnt_nxt[i];
      rd_cnt_r[i] <= sys_rst_i ? {CW{1'b1}} : rd_cnt_nxt[i];
    end
    for (int r = 0; r < 4; r++)
      pp_cnt_r[r] <= sys_rst_i ? {CW{1'b1}} : pp_cnt_nxt[r];
  end

  // ----------------------------------------
  // precharge permission per rank and bank
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      allow_o <= 32'hffffffff;
    else
      allow_o <= allow_nxt; // R13
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [4:0] h_idx_r;
  always_ff @(posedge clk_i)
    h_idx_r <= idx;

  chk_wr_pre_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R9
    cmd_i.valid && cmd_i.kind == rkm_pkg::RKM_WR && wr_gap_i > 5'h01 |=> !allow_o[h_idx_r])
    else $error("precharge allowed too soon after write");
  chk_rd_pre_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R10
    cmd_i.valid && cmd_i.kind == rkm_pkg::RKM_RD && rd_gap_i > 4'h1 |=> !allow_o[h_idx_r])
    else $error("precharge allowed too soon after read");
  chk_pp_rank_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R11
    cmd_i.valid && cmd_i.kind == rkm_pkg::RKM_PRE && pp_gap_i > 2'h1
    |=> allow_o[{h_idx_r[4:3], 3'h0} +: 8] == 8'h00)
    else $error("precharge allowed too soon after precharge");
  chk_zero_gap_free: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R13
    wr_gap_i == 5'h00 && rd_gap_i == 4'h0 && pp_gap_i == 2'h0 |=> allow_o == 32'hffffffff)
    else $error("precharge held with all gaps zero");
  cov_wr_then_pre: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    cmd_i.valid && cmd_i.kind == rkm_pkg::RKM_WR ##[1:40] cmd_i.valid && cmd_i.kind == rkm_pkg::RKM_PRE);

endmodule
`default_nettype wire

//--- hw/rkm_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "rkm_regs.svh"
module rkm_top #(
  parameter int CW = 5
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [11:0] cfg_addr_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [15:0] cfg_wdata_i,
  output logic [15:0] cfg_rdata_o,
  input wire logic stolen_region_lock_i,
  input wire logic [29:0] rank_boundary_regs_i,
  input wire logic dec_req_i,
  input wire logic [9:0] dec_addr_i,
  output logic cs_hit_o,
  output logic [1:0] cs_rank_o,
  output rkm_pkg::rkm_geom_t cs_geom_o,
  input wire rkm_pkg::rkm_cmd_t cmd_i,
  output logic [31:0] pre_allow_o
);

  // ----------------------------------------
  // configuration state
  // ----------------------------------------
  logic [9:0] top_rank_boundary_field_r;
  logic [7:0] rank_attribute_byte_r [4];
  logic [4:0] write_to_precharge_gap_r;
  logic [3:0] read_to_precharge_gap_r;
  logic [1:0] precharge_to_precharge_gap_r;
  logic [15:0] rdata_nxt;
  logic [2:0] dec_nxt;
  logic [7:0] sel_byte;
  logic wr_topb;
  logic wr_a01;
  logic wr_a23;
  logic wr_pchg;

  // ----------------------------------------
  // geometry decode of one attribute byte
  // ----------------------------------------
  function automatic rkm_pkg::rkm_geom_t geom_of(input logic [7:0] b);
    rkm_pkg::rkm_geom_t g;
    logic [2:0] n;
    logic [31:0] rows;
    logic [31:0] cols;
    logic [7:0] pg;
    g = '0;
    n = b[2:0];
    rows = `RKM_ROW_TBL;
    cols = `RKM_COL_TBL;
    pg = `RKM_PG8K_TBL;
    g.banks8 = b[`RKM_BANK8_BIT]; // R5
    if (b[`RKM_CFG_MSB:0] <= `RKM_CFG_MAX) // R4
    begin
      g.cfg_ok = 1'b1;
      g.row_bits = rows[{n, 2'b00} +: 4]; // R8
      g.col_bits = cols[{n, 2'b00} +: 4]; // R8
      g.page_8k = pg[n]; // R8
    end
    return g;
  endfunction

  // ----------------------------------------
  // rank select against ascending boundaries
  // ----------------------------------------
  function automatic logic [2:0] rank_of(input logic [9:0] a, input logic [39:0] bnd);
    rank_of = 3'b000;
    for (int r = 3; r >= 0; r--)
    begin
      if (a < bnd[r*10 +: 10])
        rank_of = {1'b1, 2'(r)}; // R12
    end
  endfunction

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  assign wr_topb = cfg_wr_i && cfg_addr_i == `RKM_TOPB_OFS && !stolen_region_lock_i; // R2
  assign wr_a01 = cfg_wr_i && cfg_addr_i == `RKM_ATTR01_OFS && !stolen_region_lock_i; // R2
  assign wr_a23 = cfg_wr_i && cfg_addr_i == `RKM_ATTR23_OFS && !stolen_region_lock_i; // R2
  assign wr_pchg = cfg_wr_i && cfg_addr_i == `RKM_PCHG_OFS;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      top_rank_boundary_field_r <= 10'h000;
    end
    else if (wr_topb)
    begin
      top_rank_boundary_field_r <= cfg_wdata_i[`RKM_TOPB_MSB:0]; // R1
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      for (int r = 0; r < 4; r++)
        rank_attribute_byte_r[r] <= 8'h00;
    end
    else
    begin
      if (wr_a01)
      begin
        rank_attribute_byte_r[0] <= cfg_wdata_i[7:0]; // R3
        rank_attribute_byte_r[1] <= cfg_wdata_i[15:8]; // R3
      end
      if (wr_a23)
      begin
        rank_attribute_byte_r[2] <= cfg_wdata_i[7:0]; // R3
        rank_attribute_byte_r[3] <= cfg_wdata_i[15:8]; // R3
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      write_to_precharge_gap_r <= 5'h00;
      read_to_precharge_gap_r <= 4'h0;
      precharge_to_precharge_gap_r <= 2'h0;
    end
    else if (wr_pchg)
    begin
      write_to_precharge_gap_r <= cfg_wdata_i[`RKM_WRG_MSB:`RKM_WRG_LSB]; // R9
      read_to_precharge_gap_r <= cfg_wdata_i[`RKM_RDG_MSB:`RKM_RDG_LSB]; // R10
      precharge_to_precharge_gap_r <= cfg_wdata_i[`RKM_PPG_MSB:`RKM_PPG_LSB]; // R11
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always_comb
  begin
    case (cfg_addr_i)
      `RKM_TOPB_OFS: rdata_nxt = {6'h00, top_rank_boundary_field_r}; // R1
      `RKM_ATTR01_OFS: rdata_nxt = {rank_attribute_byte_r[1], rank_attribute_byte_r[0]};
      `RKM_ATTR23_OFS: rdata_nxt = {rank_attribute_byte_r[3], rank_attribute_byte_r[2]};
      `RKM_PCHG_OFS: rdata_nxt = {5'h00, write_to_precharge_gap_r,
                                  read_to_precharge_gap_r, precharge_to_precharge_gap_r};
      default: rdata_nxt = `RKM_RST_VAL;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cfg_rdata_o <= `RKM_RST_VAL;
    end
    else if (cfg_rd_i)
    begin
      cfg_rdata_o <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // chip select and rank geometry
  // ----------------------------------------
  assign dec_nxt = rank_of(dec_addr_i, {top_rank_boundary_field_r, rank_boundary_regs_i});
  assign sel_byte = rank_attribute_byte_r[dec_nxt[1:0]];

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cs_hit_o <= 1'b0;
      cs_rank_o <= 2'h0;
    end
    else if (dec_req_i)
    begin
      cs_hit_o <= dec_nxt[2]; // R12
      cs_rank_o <= dec_nxt[1:0]; // R12
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cs_geom_o <= '0;
    end
    else if (dec_req_i)
    begin
      cs_geom_o <= dec_nxt[2] ? geom_of(sel_byte) : '0; // R6
    end
  end

  // ----------------------------------------
  // precharge spacing tracker
  // ----------------------------------------
  rkm_pchg_trk #(
    .CW(CW)
  ) u_trk (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .cmd_i(cmd_i),
    .wr_gap_i(write_to_precharge_gap_r),
    .rd_gap_i(read_to_precharge_gap_r),
    .pp_gap_i(precharge_to_precharge_gap_r),
    .allow_o(pre_allow_o)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_topb_rsvd_zero: assert property ( // R1
    cfg_rd_i && cfg_addr_i == `RKM_TOPB_OFS |=> cfg_rdata_o[15:10] == 6'h00)
    else $error("reserved boundary bits not zero");

  chk_lock_holds_cfg: assert property ( // R2
    stolen_region_lock_i && cfg_wr_i |=> $stable(top_rank_boundary_field_r)
    && $stable(rank_attribute_byte_r[0]) && $stable(rank_attribute_byte_r[3]))
    else $error("locked configuration changed");

  chk_attr_byte_lanes: assert property ( // R3
    cfg_wr_i && !stolen_region_lock_i && cfg_addr_i == `RKM_ATTR23_OFS
    ##1 cfg_rd_i && cfg_addr_i == `RKM_ATTR23_OFS |=> cfg_rdata_o == $past(cfg_wdata_i, 2))
    else $error("attribute bytes not kept in their lanes");

  chk_bad_cfg_flag: assert property ( // R4
    dec_req_i && dec_nxt[2] && sel_byte[6:0] > 7'h07 |=> cs_hit_o && !cs_geom_o.cfg_ok)
    else $error("unknown configuration marked valid");

  chk_bank_select: assert property ( // R5
    dec_req_i && dec_nxt[2] |=> cs_geom_o.banks8 == $past(sel_byte[7]))
    else $error("bank count not taken from bit 7");

  chk_page_4k_cfg1: assert property ( // R8
    dec_req_i && dec_nxt[2] && sel_byte[6:0] == 7'h01
    |=> !cs_geom_o.page_8k && cs_geom_o.col_bits == 4'h9 && cs_geom_o.row_bits == 4'hd)
    else $error("configuration 1 geometry wrong");

  chk_cs_above_top: assert property ( // R12
    dec_req_i && dec_addr_i >= top_rank_boundary_field_r |=> !cs_hit_o)
    else $error("chip select above top boundary");

  chk_cs_rank0: assert property ( // R12
    dec_req_i && dec_addr_i < rank_boundary_regs_i[9:0] |=> cs_hit_o && cs_rank_o == 2'h0)
    else $error("address below first boundary not rank 0");

  chk_geom_miss_zero: assert property ( // R6
    dec_req_i && !dec_nxt[2] |=> cs_geom_o == '0)
    else $error("geometry driven for unmapped address");

  chk_topb_write: assert property ( // R1
    wr_topb |=> top_rank_boundary_field_r == $past(cfg_wdata_i[`RKM_TOPB_MSB:0]))
    else $error("boundary write not taken");

  chk_lock_mid_ranks: assert property ( // R2
    stolen_region_lock_i && cfg_wr_i |=> $stable(rank_attribute_byte_r[1])
    && $stable(rank_attribute_byte_r[2]))
    else $error("locked middle rank attributes changed");

  chk_attr01_lanes: assert property ( // R3
    wr_a01 |=> {rank_attribute_byte_r[1], rank_attribute_byte_r[0]} == $past(cfg_wdata_i))
    else $error("rank 0 and 1 attribute lanes swapped");

  chk_cfg_ok_range: assert property ( // R4
    dec_req_i && dec_nxt[2] && sel_byte[6:0] <= `RKM_CFG_MAX |=> cs_geom_o.cfg_ok)
    else $error("known configuration marked invalid");

  chk_geom_cfg5: assert property ( // R8
    dec_req_i && dec_nxt[2] && sel_byte[6:0] == 7'h05
    |=> cs_geom_o.page_8k && cs_geom_o.col_bits == 4'ha && cs_geom_o.row_bits == 4'hc)
    else $error("configuration 5 geometry wrong");

  chk_pchg_fields: assert property ( // R9
    wr_pchg |=> write_to_precharge_gap_r == $past(cfg_wdata_i[`RKM_WRG_MSB:`RKM_WRG_LSB])
    && read_to_precharge_gap_r == $past(cfg_wdata_i[`RKM_RDG_MSB:`RKM_RDG_LSB])
    && precharge_to_precharge_gap_r == $past(cfg_wdata_i[`RKM_PPG_MSB:`RKM_PPG_LSB]))
    else $error("precharge spacing fields misplaced");

  chk_pchg_rsvd_zero: assert property ( // R9
    cfg_rd_i && cfg_addr_i == `RKM_PCHG_OFS |=> cfg_rdata_o[15:11] == 5'h00)
    else $error("reserved spacing bits not zero");

  chk_cs_rank1: assert property ( // R12
    dec_req_i && dec_addr_i >= rank_boundary_regs_i[9:0]
    && dec_addr_i < rank_boundary_regs_i[19:10] |=> cs_hit_o && cs_rank_o == 2'h1)
    else $error("address between first boundaries not rank 1");

  chk_cs_hold: assert property ( // R12
    !dec_req_i |=> $stable(cs_hit_o) && $stable(cs_rank_o) && $stable(cs_geom_o))
    else $error("chip select changed without request");

  cov_bad_config: cover property (dec_req_i ##1 cs_hit_o && !cs_geom_o.cfg_ok);
  cov_rank3_hit: cover property (dec_req_i ##1 cs_hit_o && cs_rank_o == 2'h3);
  cov_locked_write: cover property (stolen_region_lock_i && wr_a01 == 1'b0 && cfg_wr_i);
  cov_eight_banks: cover property (dec_req_i ##1 cs_geom_o.banks8 && cs_geom_o.cfg_ok);

endmodule
`default_nettype wire

//--- verif/rkm_dram_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// dram ranks: count precharges that arrive too early
// ----------------------------------------
module rkm_dram_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire rkm_pkg::rkm_cmd_t cmd_i,
  input wire logic [15:0] gaps_i,
  output int viol_o
);
  logic [7:0] wr_r [32];
  logic [7:0] rd_r [32];
  logic [7:0] pp_r [4];
  logic [4:0] ix;
  assign ix = {cmd_i.rank, cmd_i.bank};
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < 32; i++)
    begin
      wr_r[i] <= sys_rst_i ? 8'hff : wr_r[i] + {7'h00, ~&wr_r[i]};
      rd_r[i] <= sys_rst_i ? 8'hff : rd_r[i] + {7'h00, ~&rd_r[i]};
    end
    for (int i = 0; i < 4; i++)
    begin
      pp_r[i] <= sys_rst_i ? 8'hff : pp_r[i] + {7'h00, ~&pp_r[i]};
    end
    if (sys_rst_i)
    begin
      viol_o <= 0;
    end
    else if (cmd_i.valid)
    begin
      case (cmd_i.kind)
        rkm_pkg::RKM_WR: wr_r[ix] <= 8'h00;
        rkm_pkg::RKM_RD: rd_r[ix] <= 8'h00;
        rkm_pkg::RKM_PRE:
        begin
          pp_r[cmd_i.rank] <= 8'h00;
          if (9'(wr_r[ix]) + 9'h001 < 9'(gaps_i[10:6]) ||
              9'(rd_r[ix]) + 9'h001 < 9'(gaps_i[5:2]) ||
              9'(pp_r[cmd_i.rank]) + 9'h001 < 9'(gaps_i[1:0]))
          begin
            viol_o <= viol_o + 1;
          end
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- verif/dram_rank_map_and_precharge_timing_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dram_rank_map_and_precharge_timing_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [11:0] cfg_addr_i = 12'h000;
  logic cfg_wr_i = 1'b0;
  logic cfg_rd_i = 1'b0;
  logic [15:0] cfg_wdata_i = 16'h0000;
  logic [15:0] cfg_rdata_o;
  logic stolen_region_lock_i = 1'b0;
  logic [29:0] rank_boundary_regs_i = 30'h0;
  logic dec_req_i = 1'b0;
  logic [9:0] dec_addr_i = 10'h000;
  logic cs_hit_o;
  logic [1:0] cs_rank_o;
  rkm_pkg::rkm_geom_t cs_geom_o;
  rkm_pkg::rkm_cmd_t cmd_i = '0;
  logic [31:0] pre_allow_o;
  logic [15:0] gaps = 16'h0000;
  logic [31:0] attr;
  int viol;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  always #2 clk_i = ~clk_i;
  // ----------------------------------------
  // design and dram model
  // ----------------------------------------
  rkm_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_addr_i(cfg_addr_i),
    .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .stolen_region_lock_i(stolen_region_lock_i),
    .rank_boundary_regs_i(rank_boundary_regs_i), .dec_req_i(dec_req_i),
    .dec_addr_i(dec_addr_i), .cs_hit_o(cs_hit_o), .cs_rank_o(cs_rank_o),
    .cs_geom_o(cs_geom_o), .cmd_i(cmd_i), .pre_allow_o(pre_allow_o));
  rkm_dram_model ranks (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_i(cmd_i),
    .gaps_i(gaps), .viol_o(viol));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      n_errors = n_errors + 1;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_i);
    cfg_addr_i <= a;
    cfg_wdata_i <= d;
    cfg_wr_i <= 1'b1;
    @(posedge clk_i);
    cfg_wr_i <= 1'b0;
  endtask
  task automatic wr_rd(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_i);
    cfg_addr_i <= a;
    cfg_wdata_i <= d;
    cfg_wr_i <= 1'b1;
    @(posedge clk_i);
    cfg_wr_i <= 1'b0;
    cfg_rd_i <= 1'b1;
    @(posedge clk_i);
    cfg_rd_i <= 1'b0;
    #1;
    chk("cfg_rdata_o", {16'h0, d}, {16'h0, cfg_rdata_o});
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge clk_i);
    cfg_addr_i <= a;
    cfg_rd_i <= 1'b1;
    @(posedge clk_i);
    cfg_rd_i <= 1'b0;
    #1;
    chk("cfg_rdata_o", {16'h0, e}, {16'h0, cfg_rdata_o});
  endtask
  task automatic dec(input logic [9:0] a, input logic h, input logic [1:0] r,
    input rkm_pkg::rkm_geom_t g);
    @(posedge clk_i);
    dec_req_i <= 1'b1;
    dec_addr_i <= a;
    @(posedge clk_i);
    dec_req_i <= 1'b0;
    #1;
    chk("cs_hit_o", {31'h0, h}, {31'h0, cs_hit_o});
    if (h)
      chk("cs_rank_o", {30'h0, r}, {30'h0, cs_rank_o});
    chk("cs_geom_o", {21'h0, g}, {21'h0, cs_geom_o});
  endtask
  function automatic rkm_pkg::rkm_geom_t geom_of(input logic [7:0] b);
    rkm_pkg::rkm_geom_t g;
    g = '0;
    g.banks8 = b[7];
    if (b[6:0] <= 7'h07)
    begin
      g.cfg_ok = 1'b1;
      g.page_8k = (b[6:0] != 7'h01);
      g.col_bits = (b[6:0] == 7'h01) ? 4'h9 : 4'ha;
      g.row_bits = (b[6:0] == 7'h02 || b[6:0] == 7'h06) ? 4'he :
        (b[6:0] == 7'h05) ? 4'hc : 4'hd;
    end
    return g;
  endfunction
  task automatic pcase(input rkm_pkg::rkm_kind_t k, input logic [1:0] r, input logic [2:0] b,
    input int gap);
    logic [4:0] ix;
    ix = {r, b};
    @(posedge clk_i);
    cmd_i <= '{1'b1, k, r, b};
    @(posedge clk_i);
    cmd_i <= '0;
    for (int i = 1; i <= gap + 1; i++)
    begin
      #1;
      chk("pre_allow_o", {31'h0, i >= gap}, {31'h0, pre_allow_o[ix]});
      chk("pre_allow_o", {31'h0, k != rkm_pkg::RKM_PRE || i >= gap},
        {31'h0, pre_allow_o[ix ^ 5'h01]});
      @(posedge clk_i);
    end
    cmd_i <= '{1'b1, rkm_pkg::RKM_PRE, r, b};
    @(posedge clk_i);
    cmd_i <= '0;
    repeat (4) @(posedge clk_i);
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk("pre_allow_o", 32'hffffffff, pre_allow_o);
    rd(12'h206, 16'h0000);
    rd(12'h208, 16'h0000);
    rd(12'h20a, 16'h0000);
    rd(12'h250, 16'h0000);
    wr(12'h206, 16'hffff);
    rd(12'h206, 16'h03ff);
    wr(12'h300, 16'hffff);
    rd(12'h300, 16'h0000);
    wr(12'h250, 16'hffff);
    rd(12'h250, 16'h07ff);
    gaps = 16'h07ff;
    pcase(rkm_pkg::RKM_WR, 2'h0, 3'h2, 31);
    pcase(rkm_pkg::RKM_RD, 2'h1, 3'h5, 15);
    pcase(rkm_pkg::RKM_PRE, 2'h2, 3'h7, 3);
    wr(12'h250, 16'h00c1);
    gaps = 16'h00c1;
    pcase(rkm_pkg::RKM_WR, 2'h3, 3'h0, 3);
    pcase(rkm_pkg::RKM_RD, 2'h0, 3'h4, 0);
    pcase(rkm_pkg::RKM_PRE, 2'h1, 3'h1, 1);
    wr(12'h206, 16'h0010);
    rank_boundary_regs_i <= {10'h00c, 10'h008, 10'h004};
    for (int p = 0; p < 3; p++)
    begin
      attr = (p == 0) ? 32'h83028100 : (p == 1) ? 32'h07860584 : 32'h87007f88;
      wr(12'h208, attr[15:0]);
      wr_rd(12'h20a, attr[31:16]);
      rd(12'h208, attr[15:0]);
      for (int r = 0; r < 4; r++)
      begin
        dec(10'(r * 4 + ((r % 2) ? 0 : 3)), 1'b1, 2'(r), geom_of(attr[r * 8 +: 8]));
      end
      dec(10'h010, 1'b0, 2'h0, '0);
    end
    @(posedge clk_i);
    stolen_region_lock_i <= 1'b1;
    wr(12'h206, 16'h0020);
    wr(12'h20a, 16'h1234);
    rd(12'h206, 16'h0010);
    rd(12'h20a, 16'h8700);
    dec(10'h01f, 1'b0, 2'h0, '0);
    wr(12'h250, 16'h0155);
    rd(12'h250, 16'h0155);
    chk("viol", 32'h0, viol);
    give_verdict();
  end
endmodule
`default_nettype wire
